// ---- src/led_gate_host_pkg.sv ----
/*
 * shared constants and carriers for the led gate/pwm host controller.
 * assumes a 250 mhz system clock; times are converted to cycle counts here.
 */
package led_gate_host_pkg;

    localparam int unsigned CLOCK_MHZ          = 250;
    localparam int unsigned CHANNELS           = 3;
    // least gate low pulse, in ns
    localparam int unsigned GATE_LOW_MIN_NS    = 1000;
    localparam int unsigned GATE_LOW_MIN_CYC   =
        (GATE_LOW_MIN_NS * CLOCK_MHZ + 999) / 1000;
    // wake turn-on time from shutdown, in ns (1.4 us)
    localparam int unsigned WAKE_TURN_ON_NS    = 1400;
    localparam int unsigned WAKE_TURN_ON_CYC   =
        (WAKE_TURN_ON_NS * CLOCK_MHZ + 999) / 1000;
    // longest shutdown delay, in us; host assumes shutdown after this
    localparam int unsigned SHUTDOWN_DELAY_MAX_US = 8000;
    localparam int unsigned SHUTDOWN_DELAY_CYC    =
        SHUTDOWN_DELAY_MAX_US * CLOCK_MHZ;
    // gate dimming frequency limits, in hz
    localparam int unsigned GATE_PWM_MIN_HZ    = 100;
    localparam int unsigned GATE_PWM_FINE_MAX_HZ = 5000;
    localparam int unsigned GATE_PWM_MAX_HZ    = 50000;
    // period counts for the gate pwm (cycles per period)
    localparam int unsigned GATE_PERIOD_MAX_CYC =
        CLOCK_MHZ * 1000000 / GATE_PWM_MIN_HZ;
    localparam int unsigned GATE_PERIOD_FINE_CYC =
        CLOCK_MHZ * 1000000 / GATE_PWM_FINE_MAX_HZ;
    localparam int unsigned GATE_PERIOD_MIN_CYC =
        CLOCK_MHZ * 1000000 / GATE_PWM_MAX_HZ;
    // gate period must be this many channel periods at least
    localparam int unsigned GATE_TO_CHANNEL_RATIO = 16;
    localparam int unsigned CNT_W              = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO      = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE       = 24'h000001;

    typedef enum logic [1:0] {
        LINK_LOCKOUT,
        LINK_ACTIVE,
        LINK_WAKING,
        LINK_ASLEEP
    } link_state_e;

    typedef struct packed {
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] high_time;
    } pwm_setting_s;

    typedef struct packed {
        link_state_e            state;
        logic [CNT_W-1:0]       gate_cnt;
        logic [CNT_W-1:0]       low_cnt;
        logic [CNT_W-1:0]       wake_cnt;
        logic [CNT_W-1:0]       ch_cnt;
        logic                   gate;
        logic [CHANNELS-1:0]    drive;
        logic                   setting_bad;
    } host_state_s;

endpackage

// ---- src/led_gate_host.sv ----
/*
 * host controller for a three channel led current-sink driver: generates
 * the common gate pwm and per-channel drive pwm, tracks the driver's
 * shutdown and wake timing, and honours the supply lockout.
 * assumes all inputs synchronous to clock_in; settings are held stable
 * by the user and read combinationally on every clock cycle.
 */
`timescale 1ns/100ps

// Contract
// - gate low pulses last at least 1 us
// - gate frequency within dimming limits
// - gate much slower than channel pwm (only flagged on setting_bad_out; gate still runs)
// - drives always defined high or low
module led_gate_host #(
    parameter int unsigned SHUTDOWN_CYC = led_gate_host_pkg::SHUTDOWN_DELAY_CYC
) (
    input  wire logic                          clock_in,
    input  wire logic                          sys_rst_in,
    input  wire logic                          supply_ok_in,
    input  wire logic                          enable_in,
    input  wire led_gate_host_pkg::pwm_setting_s gate_set_in,
    input  wire led_gate_host_pkg::pwm_setting_s ch_set_in,
    input  wire logic [led_gate_host_pkg::CNT_W*
                       led_gate_host_pkg::CHANNELS-1:0] ch_high_in,
    output logic                               gate_out,
    output logic [led_gate_host_pkg::CHANNELS-1:0] channel_drive_out,
    output logic                               asleep_out,
    output logic                               waking_out,
    output logic [led_gate_host_pkg::CHANNELS-1:0] sink_expected_out,
    output logic                               setting_bad_out
);

    localparam int unsigned W  = led_gate_host_pkg::CNT_W;
    localparam int unsigned NC = led_gate_host_pkg::CHANNELS;
    localparam logic [W-1:0] LOW_MIN =
        W'(led_gate_host_pkg::GATE_LOW_MIN_CYC);
    localparam logic [W-1:0] WAKE_CYC =
        W'(led_gate_host_pkg::WAKE_TURN_ON_CYC);
    localparam logic [W-1:0] SHDN_CYC = W'(SHUTDOWN_CYC);
    localparam logic [W-1:0] PER_MAX =
        W'(led_gate_host_pkg::GATE_PERIOD_MAX_CYC);
    localparam logic [W-1:0] PER_FINE =
        W'(led_gate_host_pkg::GATE_PERIOD_FINE_CYC);
    localparam logic [W-1:0] PER_MIN =
        W'(led_gate_host_pkg::GATE_PERIOD_MIN_CYC);

    led_gate_host_pkg::host_state_s st_reg;
    led_gate_host_pkg::host_state_s st_next;

    // clamp the high time so the low part of a period lasts at least 1 us
    function automatic logic [W-1:0] clamp_high(input logic [W-1:0] per,
                                                input logic [W-1:0] hi);
        logic [W-1:0] lim;
        lim = (per > LOW_MIN) ? per - LOW_MIN : led_gate_host_pkg::CNT_ZERO;
        if (hi == led_gate_host_pkg::CNT_ZERO || hi >= per)
            return hi;
        return (hi > lim) ? lim : hi;
    endfunction

    // period counter wrap
    function automatic logic [W-1:0] step(input logic [W-1:0] cnt,
                                          input logic [W-1:0] per);
        return (cnt + led_gate_host_pkg::CNT_ONE >= per) ?
            led_gate_host_pkg::CNT_ZERO : cnt + led_gate_host_pkg::CNT_ONE;
    endfunction

    logic        period_ok;
    logic        duty_fine;
    logic        ratio_ok;
    logic [W-1:0] gate_hi;
    logic [W+4:0] ch_scaled;

    always_comb
    begin
        duty_fine = (gate_set_in.high_time * 10 > gate_set_in.period) ||
                    (gate_set_in.period >= PER_FINE);
        period_ok = (gate_set_in.period <= PER_MAX) &&
                    (gate_set_in.period >= PER_MIN) && duty_fine;
        ch_scaled = (W+5)'(ch_set_in.period) *
                    (W+5)'(led_gate_host_pkg::GATE_TO_CHANNEL_RATIO);
        ratio_ok  = (W+5)'(gate_set_in.period) >= ch_scaled;
        gate_hi   = clamp_high(gate_set_in.period, gate_set_in.high_time);
    end

    always_comb
    begin
        logic new_gate;
        logic [W-1:0] hi;
        new_gate = 1'b0;
        hi       = led_gate_host_pkg::CNT_ZERO;
        st_next  = st_reg;
        st_next.setting_bad = ~(period_ok && ratio_ok);
        st_next.gate_cnt = step(st_reg.gate_cnt, gate_set_in.period);
        st_next.ch_cnt   = step(st_reg.ch_cnt, ch_set_in.period);
        new_gate = enable_in && period_ok && (st_reg.gate_cnt < gate_hi);
        for (int i = 0; i < NC; i++)
        begin
            hi = ch_high_in[i*W +: W];
            st_next.drive[i] = enable_in && (st_reg.ch_cnt < hi);
        end
        case (st_reg.state)
            led_gate_host_pkg::LINK_LOCKOUT:
            begin
                st_next.gate  = 1'b0;
                st_next.drive = '0;
                st_next.low_cnt = led_gate_host_pkg::CNT_ZERO;
                if (supply_ok_in)
                    st_next.state = led_gate_host_pkg::LINK_ACTIVE;
            end
            led_gate_host_pkg::LINK_ACTIVE:
            begin
                st_next.gate = new_gate;
                if (new_gate)
                    st_next.low_cnt = led_gate_host_pkg::CNT_ZERO;
                else if (st_reg.low_cnt + led_gate_host_pkg::CNT_ONE
                         >= SHDN_CYC)
                    st_next.state = led_gate_host_pkg::LINK_ASLEEP;
                else
                    st_next.low_cnt = st_reg.low_cnt +
                                      led_gate_host_pkg::CNT_ONE;
            end
            led_gate_host_pkg::LINK_ASLEEP:
            begin
                st_next.gate = new_gate;
                st_next.low_cnt = led_gate_host_pkg::CNT_ZERO;
                if (new_gate)
                begin
                    st_next.wake_cnt = led_gate_host_pkg::CNT_ZERO;
                    st_next.state    = led_gate_host_pkg::LINK_WAKING;
                end
            end
            led_gate_host_pkg::LINK_WAKING:
            begin
                st_next.gate = new_gate;
                st_next.wake_cnt = st_reg.wake_cnt +
                                   led_gate_host_pkg::CNT_ONE;
                if (!new_gate)
                begin
                    st_next.low_cnt = led_gate_host_pkg::CNT_ZERO;
                    st_next.state   = led_gate_host_pkg::LINK_ACTIVE;
                end
                else if (st_next.wake_cnt >= WAKE_CYC)
                    st_next.state = led_gate_host_pkg::LINK_ACTIVE;
            end
            default:
                st_next.state = led_gate_host_pkg::LINK_LOCKOUT;
        endcase
        // supply loss returns to lockout at once
        if (!supply_ok_in)
        begin
            st_next.state = led_gate_host_pkg::LINK_LOCKOUT;
            st_next.gate  = 1'b0;
            st_next.drive = '0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            st_reg.state       <= led_gate_host_pkg::LINK_LOCKOUT;
            st_reg.gate_cnt    <= led_gate_host_pkg::CNT_ZERO;
            st_reg.low_cnt     <= led_gate_host_pkg::CNT_ZERO;
            st_reg.wake_cnt    <= led_gate_host_pkg::CNT_ZERO;
            st_reg.ch_cnt      <= led_gate_host_pkg::CNT_ZERO;
            st_reg.gate        <= 1'b0;
            st_reg.drive       <= '0;
            st_reg.setting_bad <= 1'b0;
        end
        else
            st_reg <= st_next;
    end

    assign gate_out          = st_reg.gate;
    assign channel_drive_out = st_reg.drive;
    assign asleep_out        = st_reg.state == led_gate_host_pkg::LINK_ASLEEP;
    assign waking_out        = st_reg.state == led_gate_host_pkg::LINK_WAKING;
    assign setting_bad_out   = st_reg.setting_bad;
    assign sink_expected_out =
        (st_reg.gate && st_reg.state == led_gate_host_pkg::LINK_ACTIVE) ?
        st_reg.drive : '0;

endmodule // led_gate_host

// ---- test/led_gate_host_monitor.sv ----
/* port checker for led_gate_host.
   assumes a bind from the bench and one clock domain. */
`timescale 1ns/100ps
module led_gate_host_monitor #(
    parameter int unsigned SHUTDOWN_CYC = 200
) (
    input wire logic       clock_in,
    input wire logic       sys_rst_in,
    input wire logic       supply_ok_in,
    input wire logic       gate_out,
    input wire logic [2:0] channel_drive_out,
    input wire logic       asleep_out,
    input wire logic       waking_out,
    input wire logic [2:0] sink_expected_out
);
    localparam int WAKE = led_gate_host_pkg::WAKE_TURN_ON_CYC;
    logic [23:0] low_reg;
    logic [9:0]  wake_reg;
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // run lengths seen on the pins, so the timers are judged from outside
    always_ff @(posedge clock_in)
    begin
        low_reg  <= (sys_rst_in || gate_out || !supply_ok_in) ? 24'h000000
                                                             : low_reg + 24'h000001;
        wake_reg <= waking_out ? wake_reg + 10'h001 : 10'h000;
    end
    sequence gate_fall;
        $fell(gate_out);
    endsequence
    sequence wake_cause;
        $rose(gate_out) && $past(asleep_out);
    endsequence
    AST_GATE_FALL_OFF: assert property (gate_fall |-> sink_expected_out == 3'h0)
        else $error("sinks on at gate fall");
    AST_GATE_LOW_OFF: assert property (!gate_out |-> sink_expected_out == 3'h0)
        else $error("sinks on with gate low");
    AST_DRIVE_LOW_OFF: assert property ((sink_expected_out & ~channel_drive_out) == 3'h0)
        else $error("sink on with its drive low");
    AST_DRIVE_HIGH_ON: assert property (gate_out && supply_ok_in && $past(supply_ok_in)
        && !asleep_out && !waking_out |-> sink_expected_out == channel_drive_out)
        else $error("sink does not follow drive");
    AST_LOCKOUT: assert property (!supply_ok_in |=> !gate_out && channel_drive_out == 3'h0)
        else $error("pins driven under lockout");
    AST_SHUTDOWN_DELAY: assert property ($rose(asleep_out) |-> low_reg + 3 >= SHUTDOWN_CYC
        && low_reg <= SHUTDOWN_CYC + 3) else $error("shutdown at wrong low time");
    AST_RISE_CANCELS: assert property (gate_out [*3] |-> !asleep_out)
        else $error("asleep while gate high");
    AST_WAKE_START: assert property (wake_cause |-> ##[0:2] waking_out)
        else $error("no wake window after gate rise");
    AST_WAKE_LEN: assert property ($fell(waking_out) && gate_out
        |-> wake_reg + 1 >= WAKE && wake_reg <= WAKE + 1) else $error("wake window length");
endmodule // led_gate_host_monitor

// ---- test/led_sink_model.sv ----
/* behavioural model of the three channel current-sink driver.
   assumes the host clock as its time base; pins in, sink states out. */
`timescale 1ns/100ps
module led_sink_model #(
    parameter int unsigned DELAY_CYC = 200,
    parameter int unsigned WAKE_CYC  = 350
) (
    input  wire logic       clock_in,
    input  wire logic       supply_ok_in,
    input  wire logic       gate_in,
    input  wire logic [2:0] drive_in,
    output logic [2:0]      sink_out,
    output logic            asleep_out = 1'b0,
    output logic            waking_out
);
    int unsigned low_cnt  = 0;
    int unsigned wake_cnt = 0;
    always @(posedge clock_in)
    begin
        // low timer, cleared by any gate high
        low_cnt <= gate_in ? 0 : (low_cnt < DELAY_CYC ? low_cnt + 1 : low_cnt);
        if (!gate_in && low_cnt >= DELAY_CYC)
            asleep_out <= 1'b1;
        // gate high wakes after the turn-on time
        else if (gate_in && asleep_out)
        begin
            asleep_out <= 1'b0;
            wake_cnt   <= WAKE_CYC;
        end
        else if (wake_cnt != 0)
            wake_cnt <= wake_cnt - 1;
    end
    assign waking_out = (wake_cnt != 0);
    // own drive, gated by gate, lockout, sleep and the wake window
    assign sink_out = (supply_ok_in && gate_in && !asleep_out && !waking_out)
                      ? drive_in : 3'h0;
endmodule // led_sink_model

// ---- test/led_gate_host_bench.sv ----
/* self-checking bench for led_gate_host with a driver model.
   assumes a shortened shutdown count; inputs change on falling edges. */
`timescale 1ns/100ps
module led_gate_host_bench;
    localparam int SHUT = 200;
    logic                            clock_in     = 1'b0;
    logic                            sys_rst_in   = 1'b1;
    logic                            supply_ok_in = 1'b0;
    logic                            enable_in    = 1'b1;
    led_gate_host_pkg::pwm_setting_s gate_set_in  = {24'h001388, 24'h0009c4};
    led_gate_host_pkg::pwm_setting_s ch_set_in    = {24'h00012c, 24'h000000};
    logic [71:0] ch_high_in = {24'h00012c, 24'h000096, 24'h000000};
    logic        gate_out, asleep_out, waking_out, setting_bad_out;
    logic        m_asleep, m_waking;
    logic [2:0]  channel_drive_out, sink_expected_out, m_sink;
    int          fail_count = 0;
    int          checked    = 0;
    int          d[3];
    int          n, g, bad;
    always #2 clock_in = ~clock_in;
    led_gate_host #(.SHUTDOWN_CYC(SHUT)) u_led_gate_host (.clock_in, .sys_rst_in,
        .supply_ok_in, .enable_in, .gate_set_in, .ch_set_in, .ch_high_in,
        .gate_out, .channel_drive_out, .asleep_out, .waking_out,
        .sink_expected_out, .setting_bad_out);
    led_sink_model #(.DELAY_CYC(SHUT)) u_led_sink_model (.clock_in, .supply_ok_in,
        .gate_in(gate_out), .drive_in(channel_drive_out), .sink_out(m_sink),
        .asleep_out(m_asleep), .waking_out(m_waking));
    task automatic cyc(input int k);
        repeat (k) @(negedge clock_in);
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // bounded wait on gate (0), asleep (1) or waking (2)
    task automatic wait_for(input int idx, input logic lvl, output int k);
        k = 0;
        while (((idx == 0) ? gate_out : (idx == 1) ? asleep_out
                : waking_out) !== lvl)
        begin
            cyc(1);
            k++;
            if (k > 6000)
            begin
                fail_count++;
                conclude();
            end
        end
    endtask
    // one full gate period; sink states judged only outside sleep and wake windows
    task automatic run(output int gc, output int bc);
        gc = 0;
        bc = 0;
        d = '{0, 0, 0};
        for (int i = 0; i < 5000; i++)
        begin
            cyc(1);
            gc += (gate_out === 1'b1);
            for (int j = 0; j < 3; j++)
                d[j] += (i < 300 && channel_drive_out[j] === 1'b1);
            if (!(asleep_out | waking_out | m_asleep | m_waking)
                && sink_expected_out !== m_sink)
                bc++;
        end
    endtask
    task automatic t_lockout;
        cyc(20);
        check_val({gate_out, channel_drive_out}, 4'h0);
        supply_ok_in = 1'b1;
    endtask
    task automatic t_pwm;
        cyc(5000);
        run(g, bad);
        check_val(g, gate_set_in.high_time);
        check_val(bad, 0);
        for (int j = 0; j < 3; j++)
            check_val(d[j], ch_high_in[24*j +: 24]);
    endtask
    task automatic t_cancel;
        wait_for(0, 1'b1, n);
        enable_in = 1'b0;
        cyc(150);
        enable_in = 1'b1;
        wait_for(0, 1'b1, n);
        enable_in = 1'b0;
        cyc(150);
        check_val(asleep_out, 1'b0);
        enable_in = 1'b1;
    endtask
    task automatic t_sleep;
        // start at a fresh gate rise so the wake window fits in the high phase
        wait_for(0, 1'b0, n);
        wait_for(0, 1'b1, n);
        enable_in = 1'b0;
        wait_for(1, 1'b1, n);
        check_val(n + 2 >= SHUT && n <= SHUT + 5, 1'b1);
        cyc(10);
        check_val({m_asleep, m_sink}, 4'h8);
        enable_in = 1'b1;
        wait_for(2, 1'b1, n);
        wait_for(2, 1'b0, n);
        check_val(n >= 348 && n <= 352, 1'b1);
        cyc(5);
        check_val(sink_expected_out, m_sink);
    endtask
    task automatic t_bad;
        gate_set_in.period = 24'h001387;
        cyc(20);
        check_val({setting_bad_out, gate_out}, 2'h2);
        gate_set_in.period = 24'h001388;
        ch_set_in.period = 24'h000190;
        cyc(5000);
        run(g, bad);
        check_val(setting_bad_out, 1'b1);
        check_val(g, 2500);
        ch_set_in.period = 24'h00012c;
        cyc(20);
        check_val(setting_bad_out, 1'b0);
        gate_set_in.high_time = 24'h001324;
        cyc(5000);
        run(g, bad);
        check_val(g, 5000 - led_gate_host_pkg::GATE_LOW_MIN_CYC);
        check_val(bad, 0);
        gate_set_in.high_time = 24'h0009c4;
    endtask
    initial
    begin
        cyc(10);
        sys_rst_in = 1'b0;
        t_lockout();
        t_pwm();
        t_cancel();
        t_sleep();
        t_bad();
        conclude();
    end
endmodule // led_gate_host_bench
bind led_gate_host led_gate_host_monitor #(.SHUTDOWN_CYC(SHUTDOWN_CYC))
    u_led_gate_host_monitor (.clock_in, .sys_rst_in, .supply_ok_in, .gate_out,
    .channel_drive_out, .asleep_out, .waking_out, .sink_expected_out);
